// ===== rtl/bst_tap_regs.svh
`ifndef BST_TAP_REGS_SVH
`define BST_TAP_REGS_SVH

// Instruction register width and codes
`define BST_IR_W 6
`define BST_IR_EXTEST 6'h00
`define BST_IR_SAMPLE 6'h01
`define BST_IR_CLAMP 6'h02
`define BST_IR_HIGHZ 6'h05
`define BST_IR_IDCODE 6'h20
`define BST_IR_USERCODE 6'h21
`define BST_IR_BYPASS 6'h3F
// Fixed pattern loaded by capture of the IR shift stage
`define BST_IR_CAPTURE 6'h01

// Identification word layout
`define BST_ID_W 32
`define BST_ID_VER_LSB 28
`define BST_ID_MID_LSB 12
`define BST_ID_MFR_LSB 1
`define BST_ID_MARK 1'h1

// Boundary register length
`define BST_BSR_LEN 139

`endif

// ===== rtl/bst_pkg.sv
package bst_pkg;

  // Sixteen controller states with their customary codes
  typedef enum logic [3:0]
  {
    ST_EX2_DR = 4'h0,
    ST_EX1_DR = 4'h1,
    ST_SH_DR = 4'h2,
    ST_PS_DR = 4'h3,
    ST_SEL_IR = 4'h4,
    ST_UPD_DR = 4'h5,
    ST_CAP_DR = 4'h6,
    ST_SEL_DR = 4'h7,
    ST_EX2_IR = 4'h8,
    ST_EX1_IR = 4'h9,
    ST_SH_IR = 4'hA,
    ST_PS_IR = 4'hB,
    ST_IDLE = 4'hC,
    ST_UPD_IR = 4'hD,
    ST_CAP_IR = 4'hE,
    ST_RESET = 4'hF
  } bst_state_t;

endpackage : bst_pkg

// ===== rtl/bst_scan_chain.sv
`timescale 1ns/1ps

// Boundary cell chain: capture, shift and update stages
module bst_scan_chain
#(
  parameter int LEN = 139
)
(
  input logic sys_clk,
  input logic rst_n,
  input logic capture,
  input logic shift,
  input logic update,
  input logic serialIn,
  input logic [LEN-1:0] parIn,
  output logic serialOut,
  output logic [LEN-1:0] parOut
);

  // Shift stage, cell 0 sits next to the serial output
  logic [LEN-1:0] shift_reg;
  // Update stage, holds values while shifting goes on
  logic [LEN-1:0] upd_reg;

  //////////////////////////////////////////////////////////////
  // Capture wins over shift; both come from distinct states
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      shift_reg <= '0;
    else if (capture)
      shift_reg <= parIn;
    else if (shift)
      shift_reg <= {serialIn, shift_reg[LEN-1:1]};
  end

  // Update only on request, so pins never see shifting bits
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      upd_reg <= '0;
    else if (update)
      upd_reg <= shift_reg;
  end

  assign serialOut = shift_reg[0];
  assign parOut = upd_reg;

endmodule : bst_scan_chain

// ===== rtl/bst_tap_top.sv
`timescale 1ns/1ps
`include "bst_tap_regs.svh"

// Summary of operation
// - Mode, clock, data pins plus test reset
// - Identification register selected after reset
// - Update loads new code, else identification
// - Unassigned codes behave as bypass
// - External test, sample use boundary chain
// - Identification and user code: 32-bit path
// - High-impedance and all-ones select bypass
// - Bypass is one shift stage
// - Clamp holds pins from boundary cells
// - External test drives pins from cells
// - High-impedance releases every output pin
// - Sample captures pins without disturbing them
// - Identification word fields: version, family, maker
// - User word carries part number instead
// - Every pin observed, outputs also drivable
// - Bidirectional pins own three cells
module bst_tap_top
#(
  // Pin counts; in + out + 3 * bidir gives the chain length
  parameter int NUM_IN = 40,
  parameter int NUM_OUT = 30,
  parameter int NUM_BI = 23,
  // Identity fields; all values arbitrary
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_FAMILY = 16'h1234,
  parameter logic [15:0] ID_PART = 16'h1235,
  parameter logic [10:0] ID_MAKER = 11'h055
)
(
  input logic sys_clk,
  input logic rst_n,
  input logic tck,
  input logic tms,
  input logic tdi,
  input logic trst_n,
  output logic tdo,
  output logic tdoOe,
  input logic [NUM_IN-1:0] padIn,
  output logic [NUM_IN-1:0] coreIn,
  input logic [NUM_OUT-1:0] coreOut,
  output logic [NUM_OUT-1:0] padOut,
  output logic [NUM_OUT-1:0] padOutOe,
  input logic [NUM_BI-1:0] padBiIn,
  output logic [NUM_BI-1:0] coreBiIn,
  input logic [NUM_BI-1:0] coreBiOut,
  input logic [NUM_BI-1:0] coreBiOe,
  output logic [NUM_BI-1:0] padBiOut,
  output logic [NUM_BI-1:0] padBiOe
);

  // Chain layout, inputs at the low end
  localparam int BSR_LEN = NUM_IN + NUM_OUT + 3 * NUM_BI;
  localparam int OUT_OFF = NUM_IN;
  localparam int BIN_OFF = NUM_IN + NUM_OUT;
  localparam int BOUT_OFF = BIN_OFF + NUM_BI;
  localparam int BEN_OFF = BOUT_OFF + NUM_BI;

  //////////////////////////////////////////////////////////////
  // Functions

  // Next controller state from the mode-select level
  function automatic bst_pkg::bst_state_t nextState(
    input bst_pkg::bst_state_t s,
    input logic m
  );
    bst_pkg::bst_state_t n;
    n = bst_pkg::ST_RESET;
    case (s)
      bst_pkg::ST_RESET: n = m ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: n = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: n = m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: n = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: n = m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: n = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PS_DR;
      bst_pkg::ST_PS_DR: n = m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PS_DR;
      bst_pkg::ST_EX2_DR: n = m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: n = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: n = m ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: n = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: n = m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: n = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PS_IR;
      bst_pkg::ST_PS_IR: n = m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PS_IR;
      bst_pkg::ST_EX2_IR: n = m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: n = m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      default: n = bst_pkg::ST_RESET;
    endcase
    return n;
  endfunction : nextState

  // Build an identity word; bit 0 is the fixed marker
  function automatic logic [`BST_ID_W-1:0] idWord(
    input logic [15:0] mid
  );
    logic [`BST_ID_W-1:0] w;
    w = '0;
    w[`BST_ID_W-1:`BST_ID_VER_LSB] = ID_VERSION;
    w[`BST_ID_VER_LSB-1:`BST_ID_MID_LSB] = mid;
    w[`BST_ID_MID_LSB-1:`BST_ID_MFR_LSB] = ID_MAKER;
    w[0] = `BST_ID_MARK;
    return w;
  endfunction : idWord

  //////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Test pins, two flops each before use
  logic tckS1, tckS2, tckD;
  logic tmsS1, tmsS2;
  logic tdiS1, tdiS2;
  logic trstS1, trstS2;
  // Pad inputs, same treatment
  logic [NUM_IN-1:0] padInS1, padInS2;
  logic [NUM_BI-1:0] padBiS1, padBiS2;

  // Second stages are the only readers of the first
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      {tckS1, tckS2, tckD} <= 3'h0;
      {tmsS1, tmsS2, tdiS1, tdiS2} <= 4'h0;
      {trstS1, trstS2} <= 2'h0;
    end
    else
    begin
      {tckS1, tckS2, tckD} <= {tck, tckS1, tckS2};
      {tmsS1, tmsS2} <= {tms, tmsS1};
      {tdiS1, tdiS2} <= {tdi, tdiS1};
      {trstS1, trstS2} <= {trst_n, trstS1};
    end
  end

  // Pad sampling for observation and core delivery
  always_ff @(posedge sys_clk)
  begin
    padInS1 <= padIn;
    padInS2 <= padInS1;
    padBiS1 <= padBiIn;
    padBiS2 <= padBiS1;
  end

  // Test clock edges, found from the synchronised level
  wire tckRise = tckS2 & ~tckD;
  wire tckFall = ~tckS2 & tckD;

  //////////////////////////////////////////////////////////////
  // Controller

  // Current state
  bst_pkg::bst_state_t state_reg;
  // State after the next rising test clock
  bst_pkg::bst_state_t state_next;

  assign state_next = nextState(state_reg, tmsS2);

  // Test reset acts alone
  // Needs no test clock; the system clock only samples it
  // Advance on rise
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !trstS2)
      state_reg <= bst_pkg::ST_RESET;
    else if (tckRise)
      state_reg <= state_next;
  end

  // Reset level, plus single-cycle actions each on a rising test clock
  wire inReset = (state_reg == bst_pkg::ST_RESET);
  wire capDr = tckRise && (state_reg == bst_pkg::ST_CAP_DR);
  wire shDr = tckRise && (state_reg == bst_pkg::ST_SH_DR);
  wire updDr = tckRise && (state_reg == bst_pkg::ST_UPD_DR);
  wire capIr = tckRise && (state_reg == bst_pkg::ST_CAP_IR);
  wire shIr = tckRise && (state_reg == bst_pkg::ST_SH_IR);
  wire updIr = tckRise && (state_reg == bst_pkg::ST_UPD_IR);

  //////////////////////////////////////////////////////////////
  // Instruction register

  // Shift stage, bit 0 leaves first
  logic [`BST_IR_W-1:0] irShift_reg;
  // Active instruction
  logic [`BST_IR_W-1:0] ir_reg;
  // Set once a bit has been shifted since capture
  logic irNew_reg;

  // Shift stage and its freshness flag
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || inReset)
    begin
      irShift_reg <= `BST_IR_CAPTURE;
      irNew_reg <= 1'b0;
    end
    else if (capIr)
    begin
      irShift_reg <= `BST_IR_CAPTURE;
      irNew_reg <= 1'b0;
    end
    else if (shIr)
    begin
      irShift_reg <= {tdiS2, irShift_reg[`BST_IR_W-1:1]};
      irNew_reg <= 1'b1;
    end
  end

  // Update or default
  // Stale shift contents never reach the active code
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || inReset)
      ir_reg <= `BST_IR_IDCODE;
    else if (updIr)
      ir_reg <= irNew_reg ? irShift_reg : `BST_IR_IDCODE;
  end

  wire isExtest = (ir_reg == `BST_IR_EXTEST);
  wire isSample = (ir_reg == `BST_IR_SAMPLE);
  wire isIdcode = (ir_reg == `BST_IR_IDCODE);
  wire isUser = (ir_reg == `BST_IR_USERCODE);
  wire isHighz = (ir_reg == `BST_IR_HIGHZ);
  wire isClamp = (ir_reg == `BST_IR_CLAMP);

  // Everything else bypasses
  // Path choice: chain, identity word, or bypass bit
  wire selBsr = isExtest | isSample;
  wire selId = isIdcode | isUser;

  //////////////////////////////////////////////////////////////
  // Data registers

  // Identity shift word
  logic [`BST_ID_W-1:0] idShift_reg;
  // Bypass stage
  logic byp_reg;

  wire [`BST_ID_W-1:0] idNext = isUser ? idWord(ID_PART) : idWord(ID_FAMILY);

  // Identity word capture and shift
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      idShift_reg <= '0;
    else if (capDr && selId)
      idShift_reg <= idNext;
    else if (shDr && selId)
      idShift_reg <= {tdiS2, idShift_reg[`BST_ID_W-1:1]};
  end

  // One-stage bypass
  // Captures zero, as bypass always does
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      byp_reg <= 1'b0;
    else if (capDr)
      byp_reg <= 1'b0;
    else if (shDr)
      byp_reg <= tdiS2;
  end

  //////////////////////////////////////////////////////////////
  // Boundary chain

  // Parallel values seen by capture and held by update
  logic [BSR_LEN-1:0] bsrCap;
  logic [BSR_LEN-1:0] bsrUpd;
  logic bsrOut;

  assign bsrCap = {coreBiOe, coreBiOut, padBiS2, coreOut, padInS2};

  // Chain only moves when its instruction is active
  bst_scan_chain #(
    .LEN(BSR_LEN)
  ) u_chain (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .capture(capDr && selBsr),
    .shift(shDr && selBsr),
    .update(updDr && selBsr),
    .serialIn(tdiS2),
    .parIn(bsrCap),
    .serialOut(bsrOut),
    .parOut(bsrUpd)
  );

  //////////////////////////////////////////////////////////////
  // Pin drive

  // Clamp holds update
  // Update stage is frozen under clamp: only chain updates load it
  wire testDrive = isExtest | isClamp;
  // Sample leaves the functional path alone
  wire [NUM_OUT-1:0] outNext = testDrive ? bsrUpd[OUT_OFF +: NUM_OUT] : coreOut;
  wire [NUM_BI-1:0] biNext = testDrive ? bsrUpd[BOUT_OFF +: NUM_BI] : coreBiOut;
  wire [NUM_BI-1:0] biEnSel = testDrive ? bsrUpd[BEN_OFF +: NUM_BI] : coreBiOe;
  wire [NUM_OUT-1:0] outEnNext = isHighz ? '0 : '1;
  wire [NUM_BI-1:0] biEnNext = isHighz ? '0 : biEnSel;

  // Registered pads; costs one system clock of latency
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      padOut <= '0;
      padOutOe <= '0;
      padBiOut <= '0;
      padBiOe <= '0;
    end
    else
    begin
      padOut <= outNext;
      padOutOe <= outEnNext;
      padBiOut <= biNext;
      padBiOe <= biEnNext;
    end
  end

  // Core always sees the real pads, even during test
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      coreIn <= '0;
      coreBiIn <= '0;
    end
    else
    begin
      coreIn <= padInS2;
      coreBiIn <= padBiS2;
    end
  end

  //////////////////////////////////////////////////////////////
  // Serial output

  // Bit presented while shifting data
  wire drBit = selBsr ? bsrOut : (selId ? idShift_reg[0] : byp_reg);
  wire shiftingDr = (state_reg == bst_pkg::ST_SH_DR);
  wire shiftingIr = (state_reg == bst_pkg::ST_SH_IR);

  // Falling edge output
  // Changing on the fall gives the tester half a period of setup
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !trstS2)
    begin
      tdo <= 1'b0;
      tdoOe <= 1'b0;
    end
    else if (tckFall)
    begin
      tdo <= shiftingIr ? irShift_reg[0] : drBit;
      tdoOe <= shiftingDr | shiftingIr;
    end
  end

endmodule : bst_tap_top

// ===== dv/bst_tap_sva.sv
`timescale 1ns/1ps

// Watches link and pad timing from the top's ports
module bst_tap_sva
#(
  parameter int NUM_IN = 40,
  parameter int NUM_OUT = 30,
  parameter int NUM_BI = 23
)
(
  input logic sys_clk,
  input logic rst_n,
  input logic tck,
  input logic trst_n,
  input logic tdo,
  input logic tdoOe,
  input logic [NUM_IN-1:0] padIn,
  input logic [NUM_IN-1:0] coreIn,
  input logic [NUM_OUT-1:0] padOutOe,
  input logic [NUM_BI-1:0] padBiOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////
  // A fall is seen three cycles late, so tck was low throughout
  property p_tdo_fall;
    $changed(tdo) |-> !tck && !$past(tck) && !$past(tck, 2);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo moved outside the tck low phase");
  property p_oe_fall;
    $changed(tdoOe) |-> !tck && !$past(tck) && !$past(tck, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("tdoOe moved outside the tck low phase");
  property p_tdo_hold;
    $changed(tdo) |=> $stable(tdo)[*3];
  endproperty
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("tdo did not stand");
  property p_oe_hold;
    $rose(tdoOe) |-> (tdoOe || !trst_n)[*6];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("tdoOe dropped inside a shift period");
  // Bidir enables follow the output enables into release
  property p_highz;
    padOutOe == '0 |-> padBiOe == '0;
  endproperty
  a_highz: assert property (p_highz)
    else $error("bidir enable left on while outputs released");
  property p_oe_even;
    &padOutOe || ~|padOutOe;
  endproperty
  a_oe_even: assert property (p_oe_even)
    else $error("output enables disagree");
  property p_trst;
    !trst_n [*5] |-> !tdoOe && !tdo;
  endproperty
  a_trst: assert property (p_trst)
    else $error("test reset left tdo driven");
  property p_core_in;
    $past(rst_n) && $past(rst_n, 2) |-> coreIn == $past(padIn, 3);
  endproperty
  a_core_in: assert property (p_core_in)
    else $error("coreIn not following pads");
  c_shift: cover property ($rose(tdoOe));
  c_highz: cover property ($fell(padOutOe[0]));
  c_trst: cover property (!trst_n [*5]);
endmodule : bst_tap_sva

bind bst_tap_top bst_tap_sva #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .NUM_BI(NUM_BI)) u_sva (.sys_clk(sys_clk),
  .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tdo(tdo), .tdoOe(tdoOe), .padIn(padIn), .coreIn(coreIn),
  .padOutOe(padOutOe), .padBiOe(padBiOe));

// ===== dv/bst_tester.sv
`timescale 1ns/1ps

// Board tester: tck low 5 cycles, high 3; idles low between frames
module bst_tester
(
  input wire logic sys_clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // one tck period
  // tdo is read late in the low phase, after it has settled
  // Entered just after an edge with tck already low; one call spans 8 sys_clk
  task automatic tick(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    o = tdo;
    @(posedge sys_clk);
    tck <= 1'b1;
    repeat (3) @(posedge sys_clk);
    tck <= 1'b0;
  endtask : tick

  // Walk the controller, mode bits taken LSB first
  task automatic walk(input logic [7:0] ms, input int n);
    logic o;
    for (int i = 0; i < n; i++)
      tick(ms[i], 1'b0, o);
  endtask : walk

  // Shift LSB first; mode high on the last bit leaves the shift state
  task automatic shift(input int n, input logic [138:0] din, output logic [138:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
      tick(i == n - 1, din[i], dout[i]);
  endtask : shift
endmodule : bst_tester

// ===== dv/bst_tap_top_bench.sv
`timescale 1ns/1ps
`include "bst_tap_regs.svh"

module bst_tap_top_bench;
  localparam int NI = 40;
  localparam int NO = 30;
  localparam int NB = 23;
  // Identity fields: arbitrary values
  localparam logic [3:0] VER = 4'h6;
  localparam logic [15:0] FAM = 16'hC3A5;
  localparam logic [15:0] PRT = 16'h3C5A;
  localparam logic [10:0] MFR = 11'h2D3;
  localparam logic [31:0] ID_WORD = {VER, FAM, MFR, 1'b1};
  localparam logic [31:0] USER_WORD = {VER, PRT, MFR, 1'b1};
  logic sys_clk, rst_n, trst_n, tck, tms, tdi, tdo, tdoOe;
  logic [NI-1:0] padIn, coreIn;
  logic [NO-1:0] coreOut, padOut, padOutOe;
  logic [NB-1:0] padBiIn, coreBiIn, coreBiOut, coreBiOe, padBiOut, padBiOe;
  logic [138:0] q, pre;
  int fails, n_tests;

  bst_tap_top #(.ID_VERSION(VER), .ID_FAMILY(FAM), .ID_PART(PRT), .ID_MAKER(MFR)) u_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdoOe(tdoOe), .padIn(padIn),
    .coreIn(coreIn), .coreOut(coreOut), .padOut(padOut), .padOutOe(padOutOe), .padBiIn(padBiIn),
    .coreBiIn(coreBiIn), .coreBiOut(coreBiOut), .coreBiOe(coreBiOe), .padBiOut(padBiOut), .padBiOe(padBiOe));
  bst_tester u_tst (.sys_clk(sys_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [138:0] seen, input logic [138:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Data scan from idle back to idle; result lands in q
  task automatic dr(input int n, input logic [138:0] din);
    u_tst.walk(8'h01, 3);
    u_tst.shift(n, din, q);
    u_tst.walk(8'h01, 2);
  endtask : dr

  task automatic ir(input logic [5:0] code);
    logic [138:0] c;
    u_tst.walk(8'h03, 4);
    u_tst.shift(6, 139'(code), c);
    chk(c[5:0], `BST_IR_CAPTURE);
    u_tst.walk(8'h01, 2);
  endtask : ir

  task automatic t_id;
    u_tst.walk(8'h00, 1);
    dr(32, '0);
    chk(q[31:0], ID_WORD);
    ir(`BST_IR_USERCODE);
    dr(32, '0);
    chk(q[31:0], USER_WORD);
    // No shift between capture and update: default code reloads
    u_tst.walk(8'h1B, 6);
    dr(32, '0);
    chk(q[31:0], ID_WORD);
  endtask : t_id

  task automatic t_bypass;
    logic [5:0] codes [3];
    codes = '{`BST_IR_BYPASS, 6'h15, `BST_IR_HIGHZ};
    foreach (codes[i])
    begin
      ir(codes[i]);
      dr(4, 139'hB);
      chk(q[3:0], 4'h6);
      chk({padOutOe, padBiOe}, (codes[i] == `BST_IR_HIGHZ) ? '0 : {{NO{1'b1}}, coreBiOe});
    end
  endtask : t_bypass

  // Snapshot of pads, then preload inverted outputs for the next step
  task automatic t_sample;
    pre = ~{coreBiOe, coreBiOut, padBiIn, coreOut, padIn};
    ir(`BST_IR_SAMPLE);
    dr(139, pre);
    chk(q, {coreBiOe, coreBiOut, padBiIn, coreOut, padIn});
    chk(padOut, coreOut);
    chk(coreBiIn, padBiIn);
  endtask : t_sample

  task automatic t_extest;
    ir(`BST_IR_EXTEST);
    // Pads follow the new instruction one system clock after its update
    repeat (2) @(posedge sys_clk);
    chk({padOut, padBiOut, padBiOe}, {~coreOut, ~coreBiOut, ~coreBiOe});
    @(posedge sys_clk);
    padIn <= ~padIn;
    repeat (4) @(posedge sys_clk);
    dr(139, '1);
    chk(q[NI-1:0], padIn);
  endtask : t_extest

  // Pads must stay frozen while the core keeps moving
  task automatic t_clamp;
    ir(`BST_IR_CLAMP);
    @(posedge sys_clk);
    coreOut <= ~coreOut;
    repeat (4) @(posedge sys_clk);
    chk({padOut, padBiOut}, {(NO + NB){1'b1}});
    dr(4, 139'hB);
    chk(q[3:0], 4'h6);
    u_tst.walk(8'h1F, 6);
    dr(32, '0);
    chk(q[31:0], ID_WORD);
  endtask : t_clamp

  task automatic t_trst;
    ir(`BST_IR_CLAMP);
    @(posedge sys_clk);
    trst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    trst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    u_tst.walk(8'h00, 1);
    dr(32, '0);
    chk(q[31:0], ID_WORD);
  endtask : t_trst

  task automatic wrap_up;
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    trst_n = 1'b1;
    padIn = 40'hA5_3C96_0F1E;
    coreOut = 30'h2A5_C3E1;
    padBiIn = 23'h5A_3C61;
    coreBiOut = 23'h2B_1E47;
    coreBiOe = 23'h71_0F5A;
    fails = 0;
    n_tests = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_id();
    t_bypass();
    t_sample();
    t_extest();
    t_clamp();
    t_trst();
    wrap_up();
  end

  // Watchdog: the whole sequence needs well under 20000 cycles
  initial
  begin
    #400us;
    fails++;
    wrap_up();
  end
endmodule : bst_tap_top_bench
